//--- pkg/cgt_pkg.sv
package cgt_pkg;

  // command codes of the three registers
  localparam logic [7:0] CMD_GAIN_TRIM = 8'hde;
  localparam logic [7:0] CMD_ID_WORD = 8'hfc;
  localparam logic [7:0] CMD_ID_BLOCK = 8'hfd;

  // trim field layout and power-on value before the nvm load arrives
  localparam int TRIM_LSB = 0;
  localparam int TRIM_W = 4;
  localparam logic [3:0] TRIM_RESET = 4'h0;
  // unsupported upper nibble of the trim byte
  localparam logic [3:0] TRIM_HIGH_BITS = 4'h0;

  // identification lengths in data bytes
  localparam logic [2:0] ID_WORD_BYTES = 3'h2;
  localparam logic [2:0] ID_BLOCK_BYTES = 3'h6;
  // byte count sent ahead of the block data
  localparam logic [7:0] ID_BLOCK_COUNT = 8'h06;
  // answer for a read beyond the register's length
  localparam logic [7:0] READ_PAST_END = 8'hff;

  // gain step scale: adjustment is step / 2**GAIN_SHIFT
  localparam int GAIN_SHIFT = 8;

  // transaction phase
  typedef enum logic [1:0] {
    CGT_IDLE = 2'b00,
    CGT_WRITE = 2'b01,
    CGT_READ = 2'b10
  } cgt_phase_t;

  // signed gain step per trim code, in 1/256 units, strictly rising
  function automatic logic signed [4:0] cgt_gain_step(input logic [3:0] code);
    logic signed [4:0] step;
    case (code)
      4'h0: step = -5'sd9;
      4'h1: step = -5'sd8;
      4'h2: step = -5'sd6;
      4'h3: step = -5'sd5;
      4'h4: step = -5'sd4;
      4'h5: step = -5'sd3;
      4'h6: step = -5'sd2;
      4'h7: step = -5'sd1;
      4'h8: step = 5'sd1;
      4'h9: step = 5'sd3;
      4'ha: step = 5'sd4;
      4'hb: step = 5'sd5;
      4'hc: step = 5'sd6;
      4'hd: step = 5'sd8;
      4'he: step = 5'sd9;
      default: step = 5'sd10;
    endcase
    return step;
  endfunction

endpackage

//--- pkg/cgt_trim_if.sv
`timescale 1ns/1ps
// carries the trim code and current samples to the gain stage
interface cgt_trim_if;
  logic [3:0] trim_code; // active trim field
  logic sample_valid; // raw sample strobe
  logic [15:0] sample; // raw output current sample
  logic trimmed_valid; // adjusted sample strobe
  logic [15:0] trimmed; // adjusted output current sample

  modport regs (
    output trim_code,
    output sample_valid,
    output sample,
    input trimmed_valid,
    input trimmed
  );

  modport gain (
    input trim_code,
    input sample_valid,
    input sample,
    output trimmed_valid,
    output trimmed
  );
endinterface

//--- hdl/cgt_gain_apply.sv
`timescale 1ns/1ps
// scales each current sample by (1 + step/256), one cycle of latency
module cgt_gain_apply (
  input wire logic clock,
  input wire logic rst,
  cgt_trim_if.gain tif
);

  // whole state of the stage
  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } cgt_gain_state_t;

  cgt_gain_state_t g_r;
  cgt_gain_state_t g_nxt;
  logic signed [21:0] prod; // sample times signed step
  logic signed [21:0] sum; // sample plus scaled step
  logic signed [4:0] step_now; // signed step of the active trim code

  // step lookup kept on a net so the checks can read its sign bit
  assign step_now = cgt_pkg::cgt_gain_step(tif.trim_code);

  // new trim code applies to the very next sample, no output shutdown needed
  always_comb begin
    g_nxt = g_r;
    prod = 22'($signed({1'b0, tif.sample}) * step_now);
    sum = $signed({6'h00, tif.sample}) + (prod >>> cgt_pkg::GAIN_SHIFT);
    g_nxt.valid = tif.sample_valid;
    if (tif.sample_valid) begin
      // clip at full scale; the lowest step cannot go below zero
      if (sum[21:16] != 6'h00) begin
        g_nxt.value = 16'hffff;
      end else begin
        g_nxt.value = sum[15:0];
      end
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      g_r <= '0;
    end else begin
      g_r <= g_nxt;
    end
  end

  assign tif.trimmed_valid = g_r.valid;
  assign tif.trimmed = g_r.value;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  gain_monotone_a: assert property (
    tif.sample_valid && !step_now[4]
    |=> tif.trimmed_valid && tif.trimmed >= $past(tif.sample))
    else $error("positive trim lowered the reported current");

  gain_lower_a: assert property (
    tif.sample_valid && step_now[4]
    |=> tif.trimmed_valid && tif.trimmed <= $past(tif.sample))
    else $error("negative trim raised the reported current");

  gain_max_cover: cover property (tif.sample_valid && tif.trim_code == 4'hf);

endmodule

//--- hdl/cgt_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - trim byte at de, byte write and read
// - trim bits 7:4 read zero, ignore writes
// - trim code sets monotonic current reading gain
// - id word at fc, fixed two bytes
// - id block at fd, fixed six bytes
// - id writes accepted, never refused on bus
// - id writes leave contents unchanged
// - id writes raise no communication error
// - id values are hard-wired full-width constants
module cgt_regs #(
  parameter logic [15:0] ID_WORD = 16'h5a3c, // arbitrary value
  parameter logic [47:0] ID_BLOCK = 48'h665544332211 // arbitrary value
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic txn_start,
  input wire logic [7:0] txn_cmd,
  input wire logic txn_write,
  input wire logic wr_valid,
  input wire logic [7:0] wr_byte,
  input wire logic rd_req,
  input wire logic txn_stop,
  output logic cmd_hit,
  output logic rd_valid,
  output logic [7:0] rd_byte,
  output logic cml_event,
  input wire logic nvm_load,
  input wire logic [3:0] nvm_trim,
  output logic [3:0] gain_trim_code,
  input wire logic iout_valid,
  input wire logic [15:0] iout_raw,
  output logic iout_report_valid,
  output logic [15:0] iout_report
);

  // whole state of the register bank
  typedef struct packed {
    cgt_pkg::cgt_phase_t phase;
    logic [7:0] cmd; // command of the open transaction
    logic [2:0] idx; // byte position within the transfer
    logic wr_seen; // a data byte already arrived
    logic [3:0] trim; // gain trim field
    logic [7:0] rd_data; // last answered byte
    logic rd_valid; // answer strobe
    logic cml; // communication error strobe
  } cgt_state_t;

  cgt_state_t s_r;
  cgt_state_t s_nxt;
  cgt_trim_if tif ();

  // true for the three command codes owned here
  function automatic logic is_ours(input logic [7:0] cmd);
    return cmd == cgt_pkg::CMD_GAIN_TRIM || cmd == cgt_pkg::CMD_ID_WORD ||
           cmd == cgt_pkg::CMD_ID_BLOCK;
  endfunction

  // byte answered at position idx of a read of cmd
  function automatic logic [7:0] read_byte(input logic [7:0] cmd, input logic [2:0] idx,
                                           input logic [3:0] trim);
    logic [2:0] k;
    logic [7:0] b;
    k = idx - 3'h1;
    b = cgt_pkg::READ_PAST_END;
    case (cmd)
      cgt_pkg::CMD_GAIN_TRIM: begin
        if (idx == 3'h0) begin
          b = {cgt_pkg::TRIM_HIGH_BITS, trim};
        end
      end
      cgt_pkg::CMD_ID_WORD: begin
        // low byte first, as on the wire
        if (idx < cgt_pkg::ID_WORD_BYTES) begin
          b = ID_WORD[{idx[0], 3'h0} +: 8];
        end
      end
      cgt_pkg::CMD_ID_BLOCK: begin
        // count byte first, then data low byte first
        if (idx == 3'h0) begin
          b = cgt_pkg::ID_BLOCK_COUNT;
        end else if (idx <= cgt_pkg::ID_BLOCK_BYTES) begin
          b = ID_BLOCK[{k, 3'h0} +: 8];
        end
      end
      default: begin
        b = cgt_pkg::READ_PAST_END;
      end
    endcase
    return b;
  endfunction

  assign cmd_hit = is_ours(txn_cmd);

  // transaction sequencing and register updates
  always_comb begin
    s_nxt = s_r;
    s_nxt.rd_valid = 1'b0;
    s_nxt.cml = 1'b0;
    // nvm restore; a host write in the same cycle overrides it below
    if (nvm_load) begin
      s_nxt.trim = nvm_trim;
    end
    case (s_r.phase)
      cgt_pkg::CGT_IDLE: begin
        s_nxt.phase = cgt_pkg::CGT_IDLE;
      end
      cgt_pkg::CGT_WRITE: begin
        if (wr_valid) begin
          s_nxt.wr_seen = 1'b1;
          if (s_r.cmd == cgt_pkg::CMD_GAIN_TRIM) begin
            if (!s_r.wr_seen) begin
              // upper nibble dropped, takes effect at once
              s_nxt.trim = wr_byte[cgt_pkg::TRIM_LSB +: cgt_pkg::TRIM_W];
            end else begin
              // a byte write carries one data byte only
              s_nxt.cml = 1'b1;
            end
          end
          // id writes: byte swallowed, no store, no error
        end
        if (txn_stop) begin
          s_nxt.phase = cgt_pkg::CGT_IDLE;
        end
      end
      cgt_pkg::CGT_READ: begin
        if (rd_req) begin
          s_nxt.rd_valid = 1'b1;
          s_nxt.rd_data = read_byte(s_r.cmd, s_r.idx, s_r.trim);
          // position saturates, so over-long reads keep answering ff
          if (s_r.idx != 3'h7) begin
            s_nxt.idx = s_r.idx + 3'h1;
          end
        end
        if (txn_stop) begin
          s_nxt.phase = cgt_pkg::CGT_IDLE;
        end
      end
      default: begin
        s_nxt.phase = cgt_pkg::CGT_IDLE;
      end
    endcase
    // a start, repeated or not, opens a fresh transaction
    if (txn_start) begin
      s_nxt.idx = 3'h0;
      s_nxt.wr_seen = 1'b0;
      s_nxt.cmd = txn_cmd;
      if (!is_ours(txn_cmd)) begin
        s_nxt.phase = cgt_pkg::CGT_IDLE;
      end else if (txn_write) begin
        s_nxt.phase = cgt_pkg::CGT_WRITE;
      end else begin
        s_nxt.phase = cgt_pkg::CGT_READ;
      end
    end
  end

  // state register, synchronous reset
  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '{phase: cgt_pkg::CGT_IDLE, cmd: 8'h00, idx: 3'h0, wr_seen: 1'b0,
               trim: cgt_pkg::TRIM_RESET, rd_data: 8'h00, rd_valid: 1'b0, cml: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // gain stage on the current telemetry path
  assign tif.trim_code = s_r.trim;
  assign tif.sample_valid = iout_valid;
  assign tif.sample = iout_raw;

  cgt_gain_apply u_gain (
    .clock(clock),
    .rst(rst),
    .tif(tif)
  );

  assign rd_valid = s_r.rd_valid;
  assign rd_byte = s_r.rd_data;
  assign cml_event = s_r.cml;
  assign gain_trim_code = s_r.trim;
  assign iout_report_valid = tif.trimmed_valid;
  assign iout_report = tif.trimmed;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // a trim write that is first in its transaction; a start in the same cycle still stores it
  logic trim_take;
  assign trim_take = s_r.phase == cgt_pkg::CGT_WRITE && s_r.cmd == cgt_pkg::CMD_GAIN_TRIM &&
                     wr_valid && !s_r.wr_seen;

  trim_write_take_a: assert property (
    trim_take |=> gain_trim_code == $past(wr_byte[3:0]))
    else $error("trim write not stored");

  trim_high_zero_a: assert property (
    rd_valid && $past(s_r.cmd) == cgt_pkg::CMD_GAIN_TRIM && $past(s_r.idx) == 3'h0
    |-> rd_byte == {4'h0, $past(gain_trim_code)})
    else $error("trim readback wrong or upper bits set");

  id_word_high_a: assert property (
    rd_valid && $past(s_r.cmd) == cgt_pkg::CMD_ID_WORD && $past(s_r.idx) == 3'h1
    |-> rd_byte == ID_WORD[15:8])
    else $error("id word high byte wrong");

  id_block_count_a: assert property (
    rd_valid && $past(s_r.cmd) == cgt_pkg::CMD_ID_BLOCK && $past(s_r.idx) == 3'h0
    |-> rd_byte == 8'h06)
    else $error("id block count wrong");

  id_block_last_a: assert property (
    rd_valid && $past(s_r.cmd) == cgt_pkg::CMD_ID_BLOCK && $past(s_r.idx) == 3'h6
    |-> rd_byte == ID_BLOCK[47:40])
    else $error("id block last byte wrong");

  id_write_accept_a: assert property (
    txn_start && txn_write && (txn_cmd == cgt_pkg::CMD_ID_WORD ||
    txn_cmd == cgt_pkg::CMD_ID_BLOCK)
    |-> cmd_hit ##1 s_r.phase == cgt_pkg::CGT_WRITE)
    else $error("id write not accepted");

  id_write_keep_a: assert property (
    s_r.phase == cgt_pkg::CGT_WRITE && s_r.cmd != cgt_pkg::CMD_GAIN_TRIM && wr_valid &&
    !nvm_load |=> $stable(gain_trim_code))
    else $error("id write disturbed register contents");

  id_write_quiet_a: assert property (
    s_r.phase == cgt_pkg::CGT_WRITE && s_r.cmd != cgt_pkg::CMD_GAIN_TRIM
    |=> !cml_event)
    else $error("id write raised communication error");

  trim_nvm_load_a: assert property (
    nvm_load && !trim_take |=> gain_trim_code == $past(nvm_trim))
    else $error("nvm trim value not loaded");

  trim_write_cover: cover property (trim_take);
  block_read_cover: cover property (
    rd_valid && $past(s_r.cmd) == cgt_pkg::CMD_ID_BLOCK && $past(s_r.idx) == 3'h6);
  id_write_cover: cover property (
    s_r.phase == cgt_pkg::CGT_WRITE && s_r.cmd == cgt_pkg::CMD_ID_BLOCK && wr_valid);
  report_cover: cover property (iout_report_valid);

endmodule

//--- tb/cgt_host_model.sv
`timescale 1ns/1ps
// host side of the command byte stream; every change lands 1 ns after a rising edge
module cgt_host_model (
  input wire logic clock,
  input wire logic cmd_hit,
  input wire logic rd_valid,
  input wire logic [7:0] rd_byte,
  output logic txn_start,
  output logic [7:0] txn_cmd,
  output logic txn_write,
  output logic wr_valid,
  output logic [7:0] wr_byte,
  output logic rd_req,
  output logic txn_stop
);
  // idle bus at time zero
  initial begin
    txn_start = 1'b0;
    txn_cmd = 8'h00;
    txn_write = 1'b0;
    wr_valid = 1'b0;
    wr_byte = 8'h00;
    rd_req = 1'b0;
    txn_stop = 1'b0;
  end

  // start of a transaction; ack sampled while the start is held
  task automatic start(input logic [7:0] c, input logic w, output logic hit);
    @(posedge clock);
    #1;
    txn_cmd = c;
    txn_write = w;
    txn_start = 1'b1;
    #1;
    hit = cmd_hit;
    @(posedge clock);
    #1;
    txn_start = 1'b0;
    // released command shows the inverse so a stale code is never taken again
    txn_cmd = ~c;
    txn_write = ~w;
  endtask

  // one write data byte; released data shows the inverse so stale bytes never match
  task automatic put(input logic [7:0] b);
    @(posedge clock);
    #1;
    wr_byte = b;
    wr_valid = 1'b1;
    @(posedge clock);
    #1;
    wr_valid = 1'b0;
    wr_byte = ~b;
  endtask

  // one read byte, answer taken one cycle after the request edge
  task automatic get(output logic [7:0] b, output logic v);
    @(posedge clock);
    #1;
    rd_req = 1'b1;
    @(posedge clock);
    #1;
    rd_req = 1'b0;
    v = rd_valid;
    b = rd_byte;
  endtask

  // stop condition
  task automatic stop();
    @(posedge clock);
    #1;
    txn_stop = 1'b1;
    @(posedge clock);
    #1;
    txn_stop = 1'b0;
  endtask
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam logic [15:0] IDW = 16'h1e2d; // arbitrary value
  localparam logic [47:0] IDB = 48'ha1b2c3d4e5f6; // arbitrary value
  logic clock, rst, txn_start, txn_write, wr_valid, rd_req, txn_stop;
  logic cmd_hit, rd_valid, cml_event, nvm_load, iout_valid, iout_report_valid;
  logic [7:0] txn_cmd, wr_byte, rd_byte;
  logic [3:0] nvm_trim, gain_trim_code;
  logic [15:0] iout_raw, iout_report;
  int err_total = 0, samples_checked = 0, cyc = 0, cml_cnt = 0;
  // gain steps per code in 1/256 units
  int steps [16] = '{-9, -8, -6, -5, -4, -3, -2, -1, 1, 3, 4, 5, 6, 8, 9, 10};

  cgt_regs #(.ID_WORD(IDW), .ID_BLOCK(IDB)) DUT (.clock(clock), .rst(rst),
    .txn_start(txn_start), .txn_cmd(txn_cmd), .txn_write(txn_write), .wr_valid(wr_valid),
    .wr_byte(wr_byte), .rd_req(rd_req), .txn_stop(txn_stop), .cmd_hit(cmd_hit),
    .rd_valid(rd_valid), .rd_byte(rd_byte), .cml_event(cml_event), .nvm_load(nvm_load),
    .nvm_trim(nvm_trim), .gain_trim_code(gain_trim_code), .iout_valid(iout_valid),
    .iout_raw(iout_raw), .iout_report_valid(iout_report_valid), .iout_report(iout_report));
  cgt_host_model host (.clock(clock), .cmd_hit(cmd_hit), .rd_valid(rd_valid),
    .rd_byte(rd_byte), .txn_start(txn_start), .txn_cmd(txn_cmd), .txn_write(txn_write),
    .wr_valid(wr_valid), .wr_byte(wr_byte), .rd_req(rd_req), .txn_stop(txn_stop));

  // 5 ns clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // cycle ceiling well above the few hundred cycles the tests need; error pulse tally
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cml_event === 1'b1) cml_cnt <= cml_cnt + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // write one trim byte as a whole transaction
  task automatic wr_trim(input logic [7:0] b);
    logic h;
    host.start(8'hde, 1'b1, h);
    host.put(b);
    host.stop();
  endtask

  // reset values and an unmapped command
  task automatic t_reset();
    logic h, v;
    logic [7:0] b;
    chk("trim after reset", gain_trim_code, 4'h0);
    chk("report after reset", iout_report, 16'h0000);
    host.start(8'h10, 1'b0, h);
    chk("unmapped ack", h, 1'b0);
    host.get(b, v);
    chk("unmapped answer", v, 1'b0);
    host.stop();
    $display("test reset done");
  endtask

  // trim write, read-back with the upper nibble zero, extra data byte
  task automatic t_trim();
    logic h, v;
    logic [7:0] b;
    host.start(8'hde, 1'b1, h);
    chk("trim ack", h, 1'b1);
    host.put(8'hab);
    chk("trim applied", gain_trim_code, 4'hb);
    host.stop();
    host.start(8'hde, 1'b0, h);
    host.get(b, v);
    chk("trim read", {v, b}, 9'h10b);
    host.stop();
    cml_cnt = 0;
    host.start(8'hde, 1'b1, h);
    host.put(8'h05);
    host.put(8'h07);
    host.stop();
    chk("extra byte ignored", gain_trim_code, 4'h5);
    chk("extra byte error", cml_cnt, 1);
    $display("test trim done");
  endtask

  // every trim code against the reported current
  task automatic t_gain();
    for (int i = 0; i < 16; i++) begin
      wr_trim(8'(i));
      @(posedge clock);
      #1;
      iout_raw = 16'h4000;
      iout_valid = 1'b1;
      @(posedge clock);
      #1;
      iout_valid = 1'b0;
      iout_raw = 16'hbfff;
      chk("report valid", iout_report_valid, 1'b1);
      chk("report value", iout_report, 16'(16384 + 64 * steps[i]));
    end
    $display("test gain done");
  endtask

  // id reads: word low byte first, block with count ahead, ff past the end
  task automatic t_ids();
    logic h, v;
    logic [7:0] b;
    host.start(8'hfc, 1'b0, h);
    for (int i = 0; i < 3; i++) begin
      host.get(b, v);
      chk("id word byte", {v, b}, (i < 2) ? {1'b1, IDW[8*i +: 8]} : 9'h1ff);
    end
    host.stop();
    host.start(8'hfd, 1'b0, h);
    host.get(b, v);
    chk("id block count", {v, b}, 9'h106);
    for (int i = 0; i < 7; i++) begin
      host.get(b, v);
      chk("id block byte", {v, b}, (i < 6) ? {1'b1, IDB[8*i +: 8]} : 9'h1ff);
    end
    host.stop();
    $display("test id read done");
  endtask

  // writes to both id registers are acked, dropped and flag nothing
  task automatic t_id_write();
    logic h;
    cml_cnt = 0;
    for (int i = 0; i < 2; i++) begin
      host.start(8'hfc + 8'(i), 1'b1, h);
      chk("id write ack", h, 1'b1);
      host.put(8'h00);
      host.put(8'hff);
      host.stop();
    end
    chk("id write error", cml_cnt, 0);
    t_ids();
    $display("test id write done");
  endtask

  // power-up trim load
  task automatic t_nvm();
    @(posedge clock);
    #1;
    nvm_trim = 4'h9;
    nvm_load = 1'b1;
    @(posedge clock);
    #1;
    nvm_load = 1'b0;
    nvm_trim = 4'h6;
    chk("nvm trim", gain_trim_code, 4'h9);
    $display("test nvm done");
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    nvm_load = 1'b0;
    nvm_trim = 4'h0;
    iout_valid = 1'b0;
    iout_raw = 16'h0000;
    repeat (20) @(posedge clock);
    #1;
    rst = 1'b0;
    t_reset();
    t_nvm();
    t_trim();
    t_gain();
    t_ids();
    t_id_write();
    end_sim();
  end
endmodule
